// File: pkg/tmr_pkg.sv
// Constants for the reloading timer with oscillator capture
package tmr_pkg;

  // Special-function addresses
  localparam logic [7:0] TMR_ADDR_CTRL = 8'hC8;
  localparam logic [7:0] TMR_ADDR_RLD_LO = 8'hCA;
  localparam logic [7:0] TMR_ADDR_RLD_HI = 8'hCB;
  localparam logic [7:0] TMR_ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] TMR_ADDR_CNT_HI = 8'hCD;

  // Control register field positions
  localparam int unsigned TMR_B_HI_FLAG = 7;
  localparam int unsigned TMR_B_LO_FLAG = 6;
  localparam int unsigned TMR_B_LO_IRQ_EN = 5;
  localparam int unsigned TMR_B_CAP_EN = 4;
  localparam int unsigned TMR_B_SPLIT = 3;
  localparam int unsigned TMR_B_RUN = 2;
  localparam int unsigned TMR_B_UNUSED = 1;
  localparam int unsigned TMR_B_EXT_SEL = 0;

  // Values after reset, and the byte maximum
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR_BYTE_RST = 8'h00;
  localparam logic [7:0] TMR_BYTE_MAX = 8'hFF;

  // Clock dividers
  localparam int unsigned TMR_SYS_DIV = 12;
  localparam int unsigned TMR_EXT_DIV = 8;

endpackage : tmr_pkg

// File: rtl/tmr_timer2.sv
// Reloading 16-bit / dual 8-bit timer with low-frequency oscillator capture
//
// What this block does
// - Count is two software-visible bytes, low and high
// - Split bit clear selects one 16-bit reload timer
// - Clocks: system, system/12, synchronized external/8
// - 16-bit rollover loads reload, sets high flag
// - Timer interrupt enable requests on high overflows
// - Low-byte enable adds low rollover interrupts too
// - Split mode: two 8-bit timers, own reload bytes
// - Split mode: run gates high byte only
// - Per-byte select: 1 system, 0 divided source
// - Flags set on byte rollovers in every mode
// - Split interrupts: high always, low when enabled
// - Flags never cleared by hardware, only software
// - Capture: oscillator falling edge copies count, flags
// - Capture counting clock from low-byte select
// - Control layout bit 7 down, resets zero
// - Control at 0xC8, byte and bit access
// - 16-bit mode: run bit starts and stops counting
// - Capture with interrupts enabled requests per edge
`timescale 1ns/1ps
`default_nettype none

module tmr_timer2
  import tmr_pkg::*;
#(
  parameter int unsigned SYS_DIV = TMR_SYS_DIV,
  parameter int unsigned EXT_DIV = TMR_EXT_DIV
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_bit_addr_i,
  input wire logic sfr_bit_wr_i,
  input wire logic sfr_bit_wval_i,
  input wire logic sfr_bit_rd_i,
  input wire logic high_byte_clock_select_i,
  input wire logic low_byte_clock_select_i,
  input wire logic interrupt_enable_i,
  input wire logic ext_osc_i,
  input wire logic low_frequency_oscillator_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_o
);

  if (SYS_DIV < 2 || SYS_DIV > 255)
  begin : g_bad_sys_div
    $error("SYS_DIV out of range");
  end
  if (EXT_DIV < 2 || EXT_DIV > 255)
  begin : g_bad_ext_div
    $error("EXT_DIV out of range");
  end

  logic [7:0] timer_control_reg_r;
  logic [7:0] timer_control_reg_nxt;
  logic [7:0] count_low_byte_r;
  logic [7:0] count_low_byte_nxt;
  logic [7:0] count_high_byte_r;
  logic [7:0] count_high_byte_nxt;
  logic [7:0] reload_low_byte_r;
  logic [7:0] reload_low_byte_nxt;
  logic [7:0] reload_high_byte_r;
  logic [7:0] reload_high_byte_nxt;
  logic [7:0] sys_div_r;
  logic sys_tick_r;
  logic [7:0] ext_div_r;
  logic ext_tick_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic slow_s1_r;
  logic slow_s2_r;
  logic slow_s3_r;
  logic [7:0] rdata_r;
  logic irq_r;

  logic split_mode_sel;
  logic run_control;
  logic external_clock_select;
  logic osc_capture_enable;
  logic low_byte_irq_enable;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_tick;
  logic high_tick;
  logic step_wide;
  logic low_ovf;
  logic high_ovf;
  logic slow_fall;
  logic capture_ev;
  logic ctrl_bit_hit;

  assign split_mode_sel = timer_control_reg_r[TMR_B_SPLIT];
  assign run_control = timer_control_reg_r[TMR_B_RUN];
  assign external_clock_select = timer_control_reg_r[TMR_B_EXT_SEL];
  assign osc_capture_enable = timer_control_reg_r[TMR_B_CAP_EN];
  assign low_byte_irq_enable = timer_control_reg_r[TMR_B_LO_IRQ_EN];
  assign high_overflow_flag = timer_control_reg_r[TMR_B_HI_FLAG];
  assign low_overflow_flag = timer_control_reg_r[TMR_B_LO_FLAG];
  assign ctrl_bit_hit = (sfr_bit_addr_i[7:3] == TMR_ADDR_CTRL[7:3]);

  // Three-flop chains for the pin clocks: two-flop synchronizer plus one flop for edge detect
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_osc_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      slow_s1_r <= low_frequency_oscillator_i;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
    end
  end

  assign slow_fall = slow_s3_r & ~slow_s2_r;
  assign capture_ev = osc_capture_enable & slow_fall;

  // System clock divided down, one pulse per period
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sys_div_r <= TMR_BYTE_RST;
      sys_tick_r <= 1'b0;
    end
    else if (sys_div_r == 8'(SYS_DIV - 1))
    begin
      sys_div_r <= TMR_BYTE_RST;
      sys_tick_r <= 1'b1;
    end
    else
    begin
      sys_div_r <= sys_div_r + 8'h01;
      sys_tick_r <= 1'b0;
    end
  end

  // External clock rising edges divided down
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ext_div_r <= TMR_BYTE_RST;
      ext_tick_r <= 1'b0;
    end
    else if (ext_s2_r && !ext_s3_r)
    begin
      if (ext_div_r == 8'(EXT_DIV - 1))
      begin
        ext_div_r <= TMR_BYTE_RST;
        ext_tick_r <= 1'b1;
      end
      else
      begin
        ext_div_r <= ext_div_r + 8'h01;
        ext_tick_r <= 1'b0;
      end
    end
    else
    begin
      ext_tick_r <= 1'b0;
    end
  end

  // Per-byte count enable: select 1 runs every cycle
  assign low_tick = low_byte_clock_select_i
                    | (external_clock_select ? ext_tick_r : sys_tick_r);
  assign high_tick = high_byte_clock_select_i | (external_clock_select ? ext_tick_r : sys_tick_r);
  assign step_wide = ~split_mode_sel & run_control & low_tick;

  // Overflow events
  always_comb
  begin
    if (split_mode_sel)
    begin
      low_ovf = low_tick & (count_low_byte_r == TMR_BYTE_MAX);
      high_ovf = run_control & high_tick & (count_high_byte_r == TMR_BYTE_MAX);
    end
    else
    begin
      low_ovf = step_wide & (count_low_byte_r == TMR_BYTE_MAX);
      high_ovf = step_wide & (count_low_byte_r == TMR_BYTE_MAX)
                 & (count_high_byte_r == TMR_BYTE_MAX);
    end
  end

  // Count bytes; a software write wins over a count step
  always_comb
  begin
    count_low_byte_nxt = count_low_byte_r;
    count_high_byte_nxt = count_high_byte_r;
    if (split_mode_sel)
    begin
      if (low_tick)
      begin
        count_low_byte_nxt = low_ovf ? reload_low_byte_r : count_low_byte_r + 8'h01;
      end
      if (run_control && high_tick)
      begin
        count_high_byte_nxt = high_ovf ? reload_high_byte_r : count_high_byte_r + 8'h01;
      end
    end
    else if (step_wide)
    begin
      if (high_ovf)
      begin
        count_low_byte_nxt = reload_low_byte_r;
        count_high_byte_nxt = reload_high_byte_r;
      end
      else
      begin
        {count_high_byte_nxt, count_low_byte_nxt} = {count_high_byte_r, count_low_byte_r} + 16'h0001;
      end
    end
    if (sfr_wr_i && sfr_addr_i == TMR_ADDR_CNT_LO)
    begin
      count_low_byte_nxt = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == TMR_ADDR_CNT_HI)
    begin
      count_high_byte_nxt = sfr_wdata_i;
    end
  end

  // Reload bytes; a capture wins over a software write
  always_comb
  begin
    reload_low_byte_nxt = reload_low_byte_r;
    reload_high_byte_nxt = reload_high_byte_r;
    if (sfr_wr_i && sfr_addr_i == TMR_ADDR_RLD_LO)
    begin
      reload_low_byte_nxt = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == TMR_ADDR_RLD_HI)
    begin
      reload_high_byte_nxt = sfr_wdata_i;
    end
    if (capture_ev)
    begin
      reload_low_byte_nxt = count_low_byte_r;
      reload_high_byte_nxt = count_high_byte_r;
    end
  end

  // Control register: byte and bit writes, hardware set wins
  always_comb
  begin
    timer_control_reg_nxt = timer_control_reg_r;
    if (sfr_wr_i && sfr_addr_i == TMR_ADDR_CTRL)
    begin
      timer_control_reg_nxt = sfr_wdata_i;
    end
    if (sfr_bit_wr_i && ctrl_bit_hit)
    begin
      timer_control_reg_nxt[sfr_bit_addr_i[2:0]] = sfr_bit_wval_i;
    end
    timer_control_reg_nxt[TMR_B_UNUSED] = 1'b0;
    if (high_ovf || capture_ev)
    begin
      timer_control_reg_nxt[TMR_B_HI_FLAG] = 1'b1;
    end
    if (low_ovf)
    begin
      timer_control_reg_nxt[TMR_B_LO_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      timer_control_reg_r <= TMR_CTRL_RST;
    end
    else
    begin
      timer_control_reg_r <= timer_control_reg_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_low_byte_r <= TMR_BYTE_RST;
      count_high_byte_r <= TMR_BYTE_RST;
    end
    else
    begin
      count_low_byte_r <= count_low_byte_nxt;
      count_high_byte_r <= count_high_byte_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reload_low_byte_r <= TMR_BYTE_RST;
      reload_high_byte_r <= TMR_BYTE_RST;
    end
    else
    begin
      reload_low_byte_r <= reload_low_byte_nxt;
      reload_high_byte_r <= reload_high_byte_nxt;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= TMR_BYTE_RST;
    end
    else if (sfr_bit_rd_i)
    begin
      rdata_r <= {7'h00, ctrl_bit_hit & timer_control_reg_r[sfr_bit_addr_i[2:0]]};
    end
    else if (sfr_rd_i)
    begin
      unique case (sfr_addr_i)
        TMR_ADDR_CTRL: rdata_r <= timer_control_reg_r;
        TMR_ADDR_RLD_LO: rdata_r <= reload_low_byte_r;
        TMR_ADDR_RLD_HI: rdata_r <= reload_high_byte_r;
        TMR_ADDR_CNT_LO: rdata_r <= count_low_byte_r;
        TMR_ADDR_CNT_HI: rdata_r <= count_high_byte_r;
        default: rdata_r <= TMR_BYTE_RST;
      endcase
    end
  end

  // Interrupt request level from the sticky flags
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= interrupt_enable_i
               & (high_overflow_flag | (low_byte_irq_enable & low_overflow_flag));
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign irq_o = irq_r;

endmodule : tmr_timer2

`default_nettype wire

// File: dv/tmr_timer2_assertions.sv
// Port checks for the reloading timer
`timescale 1ns/1ps
`default_nettype none
module tmr_timer2_assertions
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_bit_addr_i,
  input wire logic sfr_bit_wr_i,
  input wire logic sfr_bit_wval_i,
  input wire logic sfr_bit_rd_i,
  input wire logic interrupt_enable_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_zero;
    sfr_wr_i && !sfr_bit_wr_i && sfr_addr_i == 8'hC8 && sfr_wdata_i == 8'h00;
  endsequence
  sequence s_quiet;
    !sfr_wr_i && !sfr_bit_wr_i;
  endsequence
  sequence s_set_hi;
    sfr_bit_wr_i && sfr_bit_wval_i && sfr_bit_addr_i == 8'hCF && interrupt_enable_i ##1 interrupt_enable_i;
  endsequence
  sequence s_echo;
    sfr_bit_wr_i && sfr_bit_wval_i && sfr_bit_addr_i == 8'hCD ##1 s_quiet
    ##1 s_quiet ##0 sfr_bit_rd_i && sfr_bit_addr_i == 8'hCD;
  endsequence
  a_reset_out_zero: assert property ($rose(rst_b_i) |-> sfr_rdata_o == 8'h00 && !irq_o)
    else $error("outputs not zero");
  a_rdata_holds: assert property (!sfr_rd_i && !sfr_bit_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved");
  a_irq_needs_en: assert property (!interrupt_enable_i |=> !irq_o)
    else $error("irq while disabled");
  a_unmapped_zero: assert property (sfr_rd_i && !sfr_bit_rd_i &&
    !(sfr_addr_i inside {8'hC8, [8'hCA:8'hCD]}) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_unused_bit: assert property (sfr_bit_rd_i && sfr_bit_addr_i == 8'hC9 |=> !sfr_rdata_o[0])
    else $error("unused bit not zero");
  a_bit_echo: assert property (s_echo |=> sfr_rdata_o[0])
    else $error("bit write lost");
  a_irq_on_flag: assert property (s_set_hi |=> irq_o)
    else $error("irq missing");
  a_irq_after_clear: assert property (s_zero ##1 s_quiet ##1 s_zero |=> ##1 !irq_o)
    else $error("irq after clear");
endmodule : tmr_timer2_assertions
bind tmr_timer2 tmr_timer2_assertions tmr_timer2_assertions_i (.mclk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rd_i, .sfr_bit_addr_i, .sfr_bit_wr_i, .sfr_bit_wval_i, .sfr_bit_rd_i,
  .interrupt_enable_i, .sfr_rdata_o, .irq_o);
`default_nettype wire

// File: dv/tmr_osc_model.sv
// External and low-frequency oscillator sources
`timescale 1ns/1ps
`default_nettype none
module tmr_osc_model
(
  input wire logic slow_run_i,
  output logic ext_osc_o,
  output logic slow_osc_o
);
  // Half period chosen so no edge lands on a rising clock edge
  initial
  begin
    ext_osc_o = 1'h0;
    forever #23.2 ext_osc_o = ~ext_osc_o;
  end
  // Idles high, far slower than count clock
  initial
  begin
    slow_osc_o = 1'h1;
    wait (slow_run_i);
    #2;
    forever #1000 slow_osc_o = ~slow_osc_o;
  end
endmodule : tmr_osc_model
`default_nettype wire

// File: dv/tmr_timer2_bench.sv
// Self-checking bench for the reloading timer
`timescale 1ns/1ps
`default_nettype none
module tmr_timer2_bench;
  logic clk, rst_b, wr, rd, bw, bv, br, hsel, lsel, irq_en, slow_on, ext, slow_osc, irq;
  logic [7:0] addr, wdata, baddr, rdata, v;
  int failures, checks;
  logic [9:0] itab [5] = '{10'h380, 10'h080, 10'h140, 10'h360, 10'h120};
  tmr_timer2 tmr_timer2_i (.mclk_i(clk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_bit_addr_i(baddr), .sfr_bit_wr_i(bw),
    .sfr_bit_wval_i(bv), .sfr_bit_rd_i(br), .high_byte_clock_select_i(hsel),
    .low_byte_clock_select_i(lsel), .interrupt_enable_i(irq_en), .ext_osc_i(ext),
    .low_frequency_oscillator_i(slow_osc), .sfr_rdata_o(rdata), .irq_o(irq));
  tmr_osc_model tmr_osc_model_i (.slow_run_i(slow_on), .ext_osc_o(ext), .slow_osc_o(slow_osc));
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= !b;
    bw <= b;
    addr <= a;
    baddr <= a;
    wdata <= d;
    bv <= d[0];
    @(posedge clk);
    wr <= 1'h0;
    bw <= 1'h0;
  endtask : wt
  task automatic rdv(input logic b, input logic [7:0] a);
    @(posedge clk);
    rd <= !b;
    br <= b;
    addr <= a;
    baddr <= a;
    @(posedge clk);
    rd <= 1'h0;
    br <= 1'h0;
    @(posedge clk);
    #1 v = b ? {7'h00, rdata[0]} : rdata;
  endtask : rdv
  task automatic rc(input logic b, input logic [7:0] a, input logic [7:0] e);
    rdv(b, a);
    chk(v, e);
  endtask : rc
  task automatic rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    rdv(1'h0, a);
    chk({7'h00, v >= lo && v <= hi}, 8'h01);
  endtask : rng
  task automatic ick(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask : ick
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    rst_b = 1'h0;
    {wr, rd, bw, bv, br, slow_on} = '0;
    {addr, wdata, baddr} = '0;
    {hsel, lsel, irq_en} = 3'h7;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    for (logic [7:0] a = 8'hC8; a < 8'hCE; a++)
      rc(1'h0, a, 8'h00);
    for (logic [7:0] a = 8'hC8; a != 8'hD0; a++)
    begin
      wt(1'h1, a, 8'h01);
      rc(1'h1, a, {7'h00, a != 8'hC9});
      wt(1'h1, a, 8'h00);
    end
    wt(1'h0, 8'hCA, 8'h34);
    wt(1'h0, 8'hCB, 8'h12);
    wt(1'h0, 8'hCC, 8'hFE);
    wt(1'h0, 8'hCD, 8'hFF);
    wt(1'h0, 8'hC8, 8'h04);
    wt(1'h1, 8'hCA, 8'h00);
    rc(1'h0, 8'hC8, 8'hC0);
    rc(1'h0, 8'hCC, 8'h34);
    rc(1'h0, 8'hCD, 8'h12);
    ick(1'h1);
    foreach (itab[k])
    begin
      @(posedge clk);
      irq_en <= itab[k][8];
      wt(1'h0, 8'hC8, itab[k][7:0]);
      ick(itab[k][9]);
    end
    wt(1'h0, 8'hCA, 8'hF0);
    wt(1'h0, 8'hCB, 8'hA0);
    wt(1'h0, 8'hCC, 8'hFF);
    wt(1'h0, 8'hCD, 8'hFF);
    wt(1'h0, 8'hC8, 8'h08);
    rc(1'h0, 8'hC8, 8'h48);
    rc(1'h0, 8'hCD, 8'hFF);
    rng(8'hCC, 8'hF0, 8'hFF);
    wt(1'h1, 8'hCA, 8'h01);
    wt(1'h1, 8'hCA, 8'h00);
    rc(1'h0, 8'hCD, 8'hA1);
    rc(1'h0, 8'hC8, 8'hC8);
    ick(1'h1);
    wt(1'h0, 8'hC8, 8'h00);
    wt(1'h0, 8'hC8, 8'h00);
    ick(1'h0);
    wt(1'h0, 8'hCD, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wt(1'h0, 8'hCC, 8'h00);
      @(posedge clk);
      lsel <= 1'h0;
      wt(1'h0, 8'hC8, {7'h02, k[0]});
      repeat (k ? 400 : 120) @(posedge clk);
      wt(1'h1, 8'hCA, 8'h00);
      rng(8'hCC, 8'h09, 8'h0B);
    end
    @(posedge clk);
    hsel <= 1'h0;
    wt(1'h0, 8'hC8, 8'h0C);
    repeat (120) @(posedge clk);
    wt(1'h0, 8'hC8, 8'h00);
    rng(8'hCD, 8'h09, 8'h0B);
    wt(1'h0, 8'hCD, 8'h00);
    wt(1'h0, 8'hCC, 8'h00);
    @(posedge clk);
    lsel <= 1'h1;
    wt(1'h0, 8'hC8, 8'h14);
    @(posedge clk);
    slow_on <= 1'h1;
    for (int n = 0; n < 300 && irq !== 1'h1; n++)
      @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    rc(1'h0, 8'hC8, 8'h94);
    rng(8'hCA, 8'h5A, 8'h78);
    rc(1'h0, 8'hCB, 8'h00);
    tally_and_finish();
  end
endmodule : tmr_timer2_bench
`default_nettype wire
